// File: hw/sync_mode_pkg.sv
// constants, types and mode table for the sync mode identifier
package sync_mode_pkg;
	// 125 MHz core clock
	localparam longint CLK_HZ = 64'h0000_0000_0773_5940;
	localparam longint MHZ_PER_HZ = 64'h3e8;
	localparam longint HF_UNIT_HZ = 64'ha;
	localparam int PER_W = 24;
	localparam int LINE_W = 12;
	localparam int IDX_W = 4;
	localparam int NUM_MODES = 15;

	// legal window in millihertz: 56.2 Hz, 76 Hz, 31.5 kHz, 61 kHz
	localparam longint V_MIN_MHZ = 64'hdb88;
	localparam longint V_MAX_MHZ = 64'h1_28e0;
	localparam longint H_MIN_MHZ = 64'h1e0_a6e0;
	localparam longint H_MAX_MHZ = 64'h3a2_c940;
	// longest legal period rounds down, shortest illegal one is <= floor
	localparam logic [PER_W-1:0] V_LONG_DEF =
		PER_W'(CLK_HZ * MHZ_PER_HZ / V_MIN_MHZ);
	localparam logic [PER_W-1:0] V_SHORT_DEF =
		PER_W'(CLK_HZ * MHZ_PER_HZ / V_MAX_MHZ);
	localparam logic [PER_W-1:0] H_LONG_CYC =
		PER_W'(CLK_HZ * MHZ_PER_HZ / H_MIN_MHZ);
	localparam logic [PER_W-1:0] H_SHORT_CYC =
		PER_W'(CLK_HZ * MHZ_PER_HZ / H_MAX_MHZ);

	// what the period meters can resolve
	localparam logic [PER_W-1:0] H_PER_MIN_DEF = 24'h00_03e8;
	localparam logic [PER_W-1:0] H_PER_LIMIT_DEF = 24'h00_ffff;
	localparam logic [PER_W-1:0] V_PER_MIN_DEF = 24'h03_d090;
	localparam logic [PER_W-1:0] V_PER_LIMIT_DEF = 24'h7f_ffff;

	// match tolerances: period error as a right shift, lines absolute
	localparam int H_TOL_SH = 6;
	localparam int V_TOL_SH = 5;
	localparam logic [LINE_W-1:0] LINE_TOL = 12'h008;
	localparam logic [LINE_W-1:0] XGA_LINES_MAX = 12'h330;
	localparam logic [IDX_W-1:0] IDX_XGA70 = 4'hd;
	localparam logic [IDX_W-1:0] IDX_XGA75 = 4'he;

	typedef struct packed {
		logic [15:0] hf10;
		logic [6:0] vhz;
		logic hpos;
		logic vpos;
	} mode_entry_t;

	// h frequency in 10 Hz units, nominal field rate, polarity (1 = +)
	localparam mode_entry_t MODE_TABLE [NUM_MODES] = '{
		'{16'h0c4b, 7'h46, 1'b1, 1'b0}, '{16'h0c4b, 7'h46, 1'b0, 1'b1},
		'{16'h0c4b, 7'h3c, 1'b0, 1'b0}, '{16'h0dac, 7'h42, 1'b0, 1'b0},
		'{16'h0eca, 7'h48, 1'b0, 1'b0}, '{16'h0ea6, 7'h4b, 1'b0, 1'b0},
		'{16'h0dbc, 7'h38, 1'b1, 1'b1}, '{16'h0ecc, 7'h3c, 1'b1, 1'b1},
		'{16'h1250, 7'h4b, 1'b1, 1'b1}, '{16'h12c8, 7'h48, 1'b1, 1'b1},
		'{16'h136c, 7'h4b, 1'b0, 1'b0}, '{16'h12e4, 7'h3c, 1'b0, 1'b0},
		'{16'h147d, 7'h41, 1'b0, 1'b0}, '{16'h1610, 7'h46, 1'b0, 1'b0},
		'{16'h1772, 7'h4b, 1'b1, 1'b1}};

	typedef struct packed {
		logic [PER_W-1:0] period;
		logic pol_pos;
		logic present;
		logic fast;
	} sync_meas_t;

	typedef struct packed {
		logic mode_valid;
		logic [IDX_W-1:0] mode_idx;
		logic horiz_sync_polarity;
		logic vert_sync_polarity;
		logic out_of_range;
		logic on_screen_menu_oor;
		logic downscale;
		logic power_save;
	} mode_status_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_DIV = 3'h2,
		ST_CHECK = 3'h4
	} id_state_t;

	function automatic logic [PER_W-1:0] exp_hper(input int i);
		return PER_W'(CLK_HZ / (longint'(MODE_TABLE[i].hf10) * HF_UNIT_HZ));
	endfunction

	function automatic logic [PER_W-1:0] exp_vper(input int i);
		return PER_W'(CLK_HZ / longint'(MODE_TABLE[i].vhz));
	endfunction

	function automatic logic [LINE_W-1:0] exp_lines(input int i);
		return LINE_W'(longint'(MODE_TABLE[i].hf10) * HF_UNIT_HZ /
			longint'(MODE_TABLE[i].vhz));
	endfunction

	function automatic logic per_ok(input logic [PER_W-1:0] m,
		input logic [PER_W-1:0] e, input int sh);
		logic [PER_W-1:0] d;
		d = (m > e) ? m - e : e - m;
		return d <= (e >> sh);
	endfunction

	function automatic logic lines_ok(input logic [LINE_W-1:0] m,
		input logic [LINE_W-1:0] e);
		logic [LINE_W-1:0] d;
		d = (m > e) ? m - e : e - m;
		return d <= LINE_TOL;
	endfunction
endpackage

// File: hw/sync_period_meter.sv
// period, polarity and presence meter for one sync pin
`timescale 1ns/1ps
module sync_period_meter import sync_mode_pkg::*; #(
	parameter logic [PER_W-1:0] PER_MIN = H_PER_MIN_DEF,
	parameter logic [PER_W-1:0] PER_LIMIT = H_PER_LIMIT_DEF
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic sync_in,
	output sync_meas_t meas_out,
	output logic done_out
);
	logic [1:0] sync_sr_reg;
	logic sync_d_reg;
	logic armed_reg;
	logic [PER_W-1:0] cnt_reg;
	logic [PER_W-1:0] high_reg;
	logic rise;

	assign rise = sync_sr_reg[1] & ~sync_d_reg;

	// two-stage pin synchroniser, then an edge delay stage
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync_sr_reg <= 2'h0;
			sync_d_reg <= 1'b0;
		end else if (ce_in) begin
			sync_sr_reg <= {sync_sr_reg[0], sync_in};
			sync_d_reg <= sync_sr_reg[1];
		end
	end

	// count clocks rising edge to rising edge; short high time = + pulse
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_reg <= '0;
			high_reg <= '0;
			armed_reg <= 1'b0;
			meas_out <= '0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (rise) begin
				cnt_reg <= PER_W'(1);
				high_reg <= '0;
				armed_reg <= 1'b1;
				if (armed_reg) begin
					meas_out.period <= cnt_reg;
					meas_out.pol_pos <= high_reg < (cnt_reg >> 1);
					meas_out.present <= 1'b1;
					meas_out.fast <= cnt_reg < PER_MIN;
					done_out <= 1'b1;
				end
			end else if (cnt_reg >= PER_LIMIT) begin
				// no edge for the whole limit: pin is taken as absent
				armed_reg <= 1'b0;
				meas_out.present <= 1'b0;
				meas_out.fast <= 1'b0;
			end else begin
				cnt_reg <= cnt_reg + PER_W'(1);
				if (sync_sr_reg[1]) begin
					high_reg <= high_reg + PER_W'(1);
				end
			end
		end
	end

	property p_period_taken;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && rise && armed_reg |=>
			done_out && meas_out.period == $past(cnt_reg);
	endproperty
	a_period_taken: assert property (p_period_taken)
		else $error("sync period not captured on edge");
endmodule

// File: hw/line_divider.sv
// iterative divider: total lines = v period / h period
`timescale 1ns/1ps
module line_divider import sync_mode_pkg::*; (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [PER_W-1:0] dividend_in,
	input wire logic [PER_W-1:0] divisor_in,
	output logic done_out,
	output logic [LINE_W-1:0] quot_out
);
	localparam logic [4:0] STEPS = 5'(PER_W);
	logic [PER_W:0] rem_reg;
	logic [PER_W-1:0] quo_reg;
	logic [PER_W-1:0] dvd_reg;
	logic [PER_W-1:0] dvs_reg;
	logic [PER_W-1:0] num_reg;
	logic [4:0] step_reg;
	logic busy_reg;
	logic [PER_W:0] shifted;
	logic [PER_W:0] rem_next;
	logic [PER_W-1:0] quo_next;

	assign shifted = {rem_reg[PER_W-1:0], dvd_reg[PER_W-1]};

	// restoring step: subtract when the shifted remainder allows it
	always_comb begin
		if (shifted >= {1'b0, dvs_reg}) begin
			rem_next = shifted - {1'b0, dvs_reg};
			quo_next = {quo_reg[PER_W-2:0], 1'b1};
		end else begin
			rem_next = shifted;
			quo_next = {quo_reg[PER_W-2:0], 1'b0};
		end
	end

	// one quotient bit per clock, result saturates at the line width
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rem_reg <= '0;
			quo_reg <= '0;
			dvd_reg <= '0;
			dvs_reg <= '0;
			num_reg <= '0;
			step_reg <= '0;
			busy_reg <= 1'b0;
			done_out <= 1'b0;
			quot_out <= '0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (start_in && !busy_reg) begin
				rem_reg <= '0;
				dvd_reg <= dividend_in;
				num_reg <= dividend_in;
				dvs_reg <= divisor_in;
				step_reg <= STEPS;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				dvd_reg <= dvd_reg << 1;
				rem_reg <= rem_next;
				quo_reg <= quo_next;
				step_reg <= step_reg - 5'h1;
				// quotient lands with done: no stale read
				if (step_reg == 5'h1) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
					quot_out <= (|quo_next[PER_W-1:LINE_W]) ?
						'1 : quo_next[LINE_W-1:0];
				end
			end
		end
	end

	// quotient is exact floor unless it saturated
	property p_quot_exact;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && done_out && quo_reg < PER_W'(1 << LINE_W) |=>
			longint'(quot_out) * longint'(dvs_reg) <= longint'(num_reg) &&
			longint'(quot_out + 1) * longint'(dvs_reg) > longint'(num_reg);
	endproperty
	a_quot_exact: assert property (p_quot_exact)
		else $error("line count is not v period over h period");
endmodule

// File: hw/sync_mode_identifier.sv
// display mode identifier: measures sync, matches the mode table
`timescale 1ns/1ps
// Functional notes
// - field rate outside 56.2..76 Hz is out-of-range
// - line rate outside 31.5..61 kHz is out-of-range
// - missing h or v sync enters power save
// - unmeasurable h or v rate enters power save
// - match on rates, polarities and sync-present
// - total lines equal h rate over v rate
// - accept candidate only when line count agrees
// - recount lines whenever the sync rate changes
// - clamp vertical position to counted line total
// - table holds fifteen modes, 1024x768@75 positive
// - table holds 1024x768@70 with negative polarities
// - above 1024x768 downscale and flag menu out-of-range
module sync_mode_identifier import sync_mode_pkg::*; #(
	parameter logic [PER_W-1:0] V_LONG_CYC = V_LONG_DEF,
	parameter logic [PER_W-1:0] V_SHORT_CYC = V_SHORT_DEF,
	parameter logic [PER_W-1:0] H_PER_MIN = H_PER_MIN_DEF,
	parameter logic [PER_W-1:0] H_PER_LIMIT = H_PER_LIMIT_DEF,
	parameter logic [PER_W-1:0] V_PER_MIN = V_PER_MIN_DEF,
	parameter logic [PER_W-1:0] V_PER_LIMIT = V_PER_LIMIT_DEF
) (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic hsync_detect_in,
	input wire logic vsync_detect_in,
	input wire logic [LINE_W-1:0] vpos_preset_in,
	output mode_status_t status_out,
	output logic [LINE_W-1:0] lines_out,
	output logic lines_valid_out,
	output logic [LINE_W-1:0] vpos_out,
	output logic rate_change_out,
	output logic [PER_W-1:0] hperiod_out,
	output logic [PER_W-1:0] vperiod_out
);
	sync_meas_t hm;
	sync_meas_t vm;
	logic h_done;
	logic v_done;
	logic div_done;
	logic [LINE_W-1:0] div_quot;
	logic [1:0] hdet_sr_reg;
	logic [1:0] vdet_sr_reg;
	id_state_t state_reg;
	logic [IDX_W-1:0] cand_reg;
	logic cand_hit_reg;
	logic horiz_sync_polarity_reg;
	logic vert_sync_polarity_reg;
	logic [PER_W-1:0] last_hper_reg;
	logic [PER_W-1:0] last_vper_reg;
	logic cand_hit;
	logic [IDX_W-1:0] cand_idx;
	logic h_oor;
	logic v_oor;
	logic save_now;
	logic rate_moved;
	logic start_div;

	sync_period_meter #(
		.PER_MIN(H_PER_MIN),
		.PER_LIMIT(H_PER_LIMIT)
	) u_hmeter (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.sync_in(hsync_in),
		.meas_out(hm),
		.done_out(h_done)
	);

	sync_period_meter #(
		.PER_MIN(V_PER_MIN),
		.PER_LIMIT(V_PER_LIMIT)
	) u_vmeter (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.sync_in(vsync_in),
		.meas_out(vm),
		.done_out(v_done)
	);

	line_divider u_div (
		.core_clk_in(core_clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.start_in(start_div),
		.dividend_in(vm.period),
		.divisor_in(hm.period),
		.done_out(div_done),
		.quot_out(div_quot)
	);

	assign hperiod_out = hm.period;
	assign vperiod_out = vm.period;

	// detect pins come from the analog front end, so synchronise them
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hdet_sr_reg <= 2'h0;
			vdet_sr_reg <= 2'h0;
		end else if (ce_in) begin
			hdet_sr_reg <= {hdet_sr_reg[0], hsync_detect_in};
			vdet_sr_reg <= {vdet_sr_reg[0], vsync_detect_in};
		end
	end

	// range checks on periods: long period means low frequency
	assign v_oor = vm.period > V_LONG_CYC || vm.period <= V_SHORT_CYC;
	assign h_oor = hm.period > H_LONG_CYC || hm.period <= H_SHORT_CYC;

	// absent or unmeasurable sync on either axis means power save
	assign save_now = !hdet_sr_reg[1] || !vdet_sr_reg[1] ||
		!hm.present || !vm.present ||
		hm.fast || vm.fast;

	// first table entry whose rates and polarities fit the measurement
	always_comb begin
		cand_hit = 1'b0;
		cand_idx = '0;
		for (int i = NUM_MODES - 1; i >= 0; i--) begin
			if (per_ok(hm.period, exp_hper(i), H_TOL_SH) &&
				per_ok(vm.period, exp_vper(i), V_TOL_SH) &&
				hm.pol_pos == MODE_TABLE[i].hpos &&
				vm.pol_pos == MODE_TABLE[i].vpos) begin
				cand_hit = 1'b1;
				cand_idx = IDX_W'(i);
			end
		end
	end

	// any drift beyond tolerance since the last count is a rate change
	assign rate_moved = !per_ok(hm.period, last_hper_reg, H_TOL_SH) ||
		!per_ok(vm.period, last_vper_reg, V_TOL_SH);

	// every new field outside power save restarts a count, so a changed rate is always
	// recounted even when it maps to the same mode
	assign start_div = ce_in && state_reg == ST_IDLE && v_done &&
		!save_now;

	// identification sequencer
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_IDLE;
			cand_reg <= '0;
			cand_hit_reg <= 1'b0;
			horiz_sync_polarity_reg <= 1'b0;
			vert_sync_polarity_reg <= 1'b0;
		end else if (ce_in) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_div) begin
						cand_reg <= cand_idx;
						cand_hit_reg <= cand_hit;
						horiz_sync_polarity_reg <= hm.pol_pos;
						vert_sync_polarity_reg <= vm.pol_pos;
						state_reg <= ST_DIV;
					end
				end
				ST_DIV: begin
					if (div_done) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// the line count is registered in ST_CHECK, the clock after the divider's done pulse
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lines_out <= '0;
			lines_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (save_now) begin
				lines_valid_out <= 1'b0;
			end else if (state_reg == ST_CHECK) begin
				lines_out <= div_quot;
				lines_valid_out <= 1'b1;
			end
		end
	end

	// rate-change pulse and the periods used for the last count
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			last_hper_reg <= '0;
			last_vper_reg <= '0;
			rate_change_out <= 1'b0;
		end else if (ce_in) begin
			rate_change_out <= start_div && rate_moved;
			if (start_div) begin
				last_hper_reg <= hm.period;
				last_vper_reg <= vm.period;
			end
		end
	end

	// mode decision: lines are compared after they are registered,
	// which costs a clock but keeps the divider off the compare path
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			status_out <= '0;
		end else if (ce_in) begin
			status_out.out_of_range <= h_oor || v_oor;
			status_out.power_save <= save_now;
			status_out.on_screen_menu_oor <= h_oor || v_oor ||
				status_out.downscale;
			if (save_now) begin
				status_out.mode_valid <= 1'b0;
				status_out.downscale <= 1'b0;
			end else if (state_reg == ST_CHECK) begin
				status_out.mode_valid <= cand_hit_reg &&
					lines_ok(div_quot, exp_lines(int'(cand_reg)));
				status_out.mode_idx <= cand_reg;
				status_out.horiz_sync_polarity <= horiz_sync_polarity_reg;
				status_out.vert_sync_polarity <= vert_sync_polarity_reg;
				status_out.downscale <= div_quot > XGA_LINES_MAX;
				if (div_quot > XGA_LINES_MAX) begin
					status_out.on_screen_menu_oor <= 1'b1;
				end
			end
		end
	end

	// while the line count is valid, vertical position is clamped to the counted total, one clock behind the count and its valid flag
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			vpos_out <= '0;
		end else if (ce_in) begin
			if (lines_valid_out && vpos_preset_in > lines_out) begin
				vpos_out <= lines_out;
			end else begin
				vpos_out <= vpos_preset_in;
			end
		end
	end

	property p_v_oor;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && (vm.period > V_LONG_CYC || vm.period <= V_SHORT_CYC) |=>
			status_out.out_of_range;
	endproperty
	a_v_oor: assert property (p_v_oor)
		else $error("field rate out of window not flagged");

	property p_h_oor;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && (hm.period > H_LONG_CYC || hm.period <= H_SHORT_CYC) |=>
			status_out.out_of_range && status_out.on_screen_menu_oor;
	endproperty
	a_h_oor: assert property (p_h_oor)
		else $error("line rate out of window not flagged");

	property p_absent;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && (!hm.present || !vdet_sr_reg[1]) |=>
			status_out.power_save && !status_out.mode_valid;
	endproperty
	a_absent: assert property (p_absent)
		else $error("missing sync did not enter power save");

	property p_fast;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && (hm.fast || vm.fast) |=> status_out.power_save;
	endproperty
	a_fast: assert property (p_fast)
		else $error("unmeasurable sync did not enter power save");

	property p_pol_match;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		$rose(status_out.mode_valid) |->
			MODE_TABLE[status_out.mode_idx].hpos ==
				status_out.horiz_sync_polarity &&
			MODE_TABLE[status_out.mode_idx].vpos ==
				status_out.vert_sync_polarity;
	endproperty
	a_pol_match: assert property (p_pol_match)
		else $error("mode accepted with wrong polarity");

	property p_lines_agree;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		$rose(status_out.mode_valid) |->
			lines_ok(lines_out, exp_lines(int'(status_out.mode_idx)));
	endproperty
	a_lines_agree: assert property (p_lines_agree)
		else $error("mode accepted with disagreeing line count");

	property p_recount;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		start_div |=> state_reg == ST_DIV ##[1:60] state_reg == ST_CHECK;
	endproperty
	a_recount: assert property (p_recount)
		else $error("new field did not start a line recount");

	property p_vpos_clamp;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && lines_valid_out |=>
			vpos_out <= $past(lines_out) &&
			(vpos_out == $past(vpos_preset_in) ||
			vpos_out == $past(lines_out));
	endproperty
	a_vpos_clamp: assert property (p_vpos_clamp)
		else $error("vertical position beyond line total");

	property p_xga75;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		status_out.mode_valid && status_out.mode_idx == IDX_XGA75 |->
			status_out.horiz_sync_polarity && status_out.vert_sync_polarity;
	endproperty
	a_xga75: assert property (p_xga75)
		else $error("1024x768 at 75 Hz needs positive syncs");

	property p_xga70;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		status_out.mode_valid && status_out.mode_idx == IDX_XGA70 |->
			!status_out.horiz_sync_polarity &&
			!status_out.vert_sync_polarity;
	endproperty
	a_xga70: assert property (p_xga70)
		else $error("1024x768 at 70 Hz needs negative syncs");

	property p_downscale;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		ce_in && state_reg == ST_CHECK && !save_now &&
			div_quot > XGA_LINES_MAX |=>
			status_out.downscale && status_out.on_screen_menu_oor;
	endproperty
	a_downscale: assert property (p_downscale)
		else $error("oversized input not downscaled and flagged");
endmodule

// File: testbench/host_sync_model.sv
// behavioural graphics source: free-running h and v sync generator
`timescale 1ns/1ps
module host_sync_model import sync_mode_pkg::*; (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic [PER_W-1:0] hper_in,
	input wire logic [PER_W-1:0] hhigh_in,
	input wire logic [PER_W-1:0] vper_in,
	input wire logic [PER_W-1:0] vhigh_in,
	input wire logic hen_in,
	output logic hsync_out,
	output logic vsync_out
);
	logic [PER_W-1:0] hcnt, vcnt, hp, hh, vp, vh;
	// new timing taken only at a wrap, so no stray short period appears
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hcnt <= '0;
			vcnt <= '0;
			hp <= hper_in;
			hh <= hhigh_in;
			vp <= vper_in;
			vh <= vhigh_in;
		end else begin
			hcnt <= (hcnt + 1 >= hp) ? '0 : hcnt + 1;
			vcnt <= (vcnt + 1 >= vp) ? '0 : vcnt + 1;
			if (hcnt + 1 >= hp) begin
				hp <= hper_in;
				hh <= hhigh_in;
			end
			if (vcnt + 1 >= vp) begin
				vp <= vper_in;
				vh <= vhigh_in;
			end
		end
	end
	// high for the first part of each period; a switched-off h line idles low
	assign hsync_out = hen_in && (hcnt < hh);
	assign vsync_out = vcnt < vh;
endmodule

// File: testbench/sync_mode_identifier_tb_top.sv
// self-checking bench for the sync mode identifier
`timescale 1ns/1ps
module sync_mode_identifier_tb_top import sync_mode_pkg::*; ;
	localparam int NC = 14;
	// v counts shrunk so that a field lasts a few thousand clocks
	localparam logic [PER_W-1:0] V_LONG = 24'h00_1000;
	localparam logic [PER_W-1:0] V_SHORT = 24'h00_0800;
	localparam logic [PER_W-1:0] V_MIN = 24'h00_0100;
	localparam logic [PER_W-1:0] V_LIMIT = 24'h00_4000;
	localparam logic [PER_W-1:0] H_MIN = 24'h00_0003;
	localparam logic [PER_W-1:0] H_LIMIT = 24'h00_1000;
	// per case: h period, h high time, v period, v high time
	logic [15:0] hp_t [NC] = '{16'h09c4, 16'h09c4, 16'h0801, 16'h0802,
		16'h0f80, 16'h0f81, 16'h0003, 16'h09c4, 16'h09c4, 16'h09c4,
		16'h0002, 16'h09c4, 16'h09c4, 16'h09c4};
	logic [15:0] hh_t [NC] = '{16'h0064, 16'h0064, 16'h07d0, 16'h0064,
		16'h0064, 16'h0064, 16'h0001, 16'h0064, 16'h0064, 16'h0064,
		16'h0001, 16'h0064, 16'h0064, 16'h0064};
	logic [15:0] vp_t [NC] = '{16'h0bb8, 16'h0bb8, 16'h0bb8, 16'h1000,
		16'h0801, 16'h1001, 16'h0bb8, 16'h0800, 16'h0bb8, 16'h0bb8,
		16'h0bb8, 16'h00c8, 16'h1388, 16'h0bb8};
	logic [15:0] vh_t [NC] = '{16'h0005, 16'h0005, 16'h0bae, 16'h0005,
		16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0005,
		16'h0005, 16'h0005, 16'h0005, 16'h0b54};
	// h line on, h present, v present, one bit per case
	logic [NC-1:0] he_t = 14'h2fff;
	logic [NC-1:0] hd_t = 14'h3eff;
	logic [NC-1:0] vd_t = 14'h3dff;
	logic clk, rst_n, hdet, vdet, hen, hs, vs, lines_v, rc;
	logic ps, oor, moved, prev_ps;
	logic [PER_W-1:0] hper, hhigh, vper, vhigh, hmeas, vmeas;
	logic [LINE_W-1:0] preset, lines, vpos;
	logic [31:0] lfsr;
	mode_status_t status;
	int error_cnt, comparisons, rc_cnt, base, lines_e, pv, dh, dv, hwait;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
	endfunction

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always #4 clk = ~clk;

	// pulses of the rate-change flag, read between cases
	always @(posedge clk) begin
		if (rc === 1'b1) begin
			rc_cnt++;
		end
	end

	host_sync_model partner (.core_clk_in(clk), .arst_n_in(rst_n),
		.hper_in(hper), .hhigh_in(hhigh), .vper_in(vper), .vhigh_in(vhigh),
		.hen_in(hen), .hsync_out(hs), .vsync_out(vs));

	sync_mode_identifier #(.V_LONG_CYC(V_LONG), .V_SHORT_CYC(V_SHORT),
		.H_PER_MIN(H_MIN), .H_PER_LIMIT(H_LIMIT), .V_PER_MIN(V_MIN),
		.V_PER_LIMIT(V_LIMIT)) dut (.core_clk_in(clk), .arst_n_in(rst_n),
		.ce_in(1'b1), .hsync_in(hs), .vsync_in(vs), .hsync_detect_in(hdet),
		.vsync_detect_in(vdet), .vpos_preset_in(preset),
		.status_out(status), .lines_out(lines), .lines_valid_out(lines_v),
		.vpos_out(vpos), .rate_change_out(rc), .hperiod_out(hmeas),
		.vperiod_out(vmeas));

	// roughly 96k clocks of cases; a hang is cut off after that
	initial begin
		repeat (99000) @(posedge clk);
		error_cnt++;
		results();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		hdet = 1'b1;
		vdet = 1'b1;
		hen = 1'b1;
		hper = PER_W'(hp_t[0]);
		hhigh = PER_W'(hh_t[0]);
		vper = PER_W'(vp_t[0]);
		vhigh = PER_W'(vh_t[0]);
		preset = 12'h000;
		lfsr = 32'ha5ede82e;
		error_cnt = 0;
		comparisons = 0;
		rc_cnt = 0;
		pv = 32'h0;
		prev_ps = 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk);
		check("status_in_reset", status, 32'h0);
		check("vpos_in_reset", vpos, 32'h0);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("power_save_start", status.power_save, 32'h1);
		for (int i = 0; i < NC; i++) begin
			@(posedge clk);
			preset <= lfsr[11:0];
			lfsr = lfsr_next(lfsr);
			hper <= PER_W'(hp_t[i]);
			hhigh <= PER_W'(hh_t[i]);
			vper <= PER_W'(vp_t[i]);
			vhigh <= PER_W'(vh_t[i]);
			hen <= he_t[i];
			hdet <= hd_t[i];
			vdet <= vd_t[i];
			base = rc_cnt;
			// new h timing lands at an h wrap, then needs a whole period
			hwait = pv;
			if (i > 0 && (hp_t[i] != hp_t[i-1] || hh_t[i] != hh_t[i-1] ||
				he_t[i] != he_t[i-1])) begin
				hwait = int'(hp_t[i-1]) + int'(hp_t[i]);
				hwait = (hwait > pv) ? hwait : pv;
			end
			// old field drains, one whole new field, then the divide
			repeat (hwait + int'(vp_t[i]) + 40) @(posedge clk);
			@(negedge clk);
			ps = !he_t[i] || !hd_t[i] || !vd_t[i] || hp_t[i] < H_MIN ||
				vp_t[i] < V_MIN;
			oor = vp_t[i] > V_LONG || vp_t[i] <= V_SHORT ||
				hp_t[i] > H_LONG_CYC || hp_t[i] <= H_SHORT_CYC;
			lines_e = int'(vp_t[i]) / int'(hp_t[i]);
			check("power_save", status.power_save, ps);
			if (ps) begin
				check("lines_valid", lines_v, 32'h0);
				check("vpos", vpos, preset);
			end else begin
				check("out_of_range", status.out_of_range, oor);
				check("lines", lines, lines_e);
				check("lines_valid", lines_v, 32'h1);
				check("vpos", vpos, (int'(preset) > lines_e) ?
					lines_e : preset);
				check("downscale", status.downscale, lines_e > 816);
				check("menu_oor", status.on_screen_menu_oor,
					oor || lines_e > 816);
				check("mode_valid", status.mode_valid, 32'h0);
				check("horiz_sync_polarity", status.horiz_sync_polarity,
					hh_t[i] * 2 < hp_t[i]);
				check("vert_sync_polarity", status.vert_sync_polarity,
					vh_t[i] * 2 < vp_t[i]);
				check("hperiod", hmeas, hp_t[i]);
				check("vperiod", vmeas, vp_t[i]);
				if (i > 0 && !prev_ps) begin
					dh = int'(hp_t[i]) - int'(hp_t[i-1]);
					dv = int'(vp_t[i]) - int'(vp_t[i-1]);
					dh = (dh < 0) ? -dh : dh;
					dv = (dv < 0) ? -dv : dv;
					moved = dh > int'(hp_t[i-1] >> 6) ||
						dv > int'(vp_t[i-1] >> 5);
					check("rate_change", rc_cnt != base, moved);
				end
			end
			prev_ps = ps;
			pv = int'(vp_t[i]);
		end
		results();
	end
endmodule
